// file: mcal_top.sv
// Multi-device clock alignment block with APB register access
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mcal_top
    import mcal_pkg::*;
(
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [mcal_pkg::ADDR_W-1:0] paddr,
    input  wire logic [mcal_pkg::DATA_W-1:0] pwdata,
    output logic      [mcal_pkg::DATA_W-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Device pins
    input  wire logic                        sync_in,
    input  wire logic                        commit_in,
    output logic                             sync_out,
    output logic                             sync_clk_out,
    // Interrupt
    output logic                             irq
);
    import mcal_pkg::*;

    // ==========================================================
    // Signals
    logic [1:0]        fc1_buf_reg;
    logic [1:0]        fc1_act_reg;
    logic [7:0]        fc2_buf_reg;
    logic [7:0]        fc2_act_reg;
    logic              sync_lost_reg;
    logic [IRQ_W-1:0]  irq_stat_reg;
    logic [IRQ_W-1:0]  irq_mask_reg;
    logic              stall_reg;
    logic              commit_samp_reg;
    logic              sync_out_reg;
    logic              sync_clk_reg;
    logic              irq_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic [1:0]        phase;
    logic              rise_tick;
    logic              sin_level;
    logic              sin_rise;
    logic              cmt_level;
    logic              access;
    logic              wr_en;
    logic              rd_en;
    logic              mapped;
    logic              commit_go;
    logic              act_master;
    logic              act_slave;
    logic              act_mask;
    logic              act_sw;
    logic              act_hw;
    logic [1:0]        act_ofs;
    logic [1:0]        expect_phase;
    logic              align_hit;
    logic              mismatch;
    logic              sw_stall;
    logic              hw_stall;
    logic              align_stall;
    logic [IRQ_W-1:0]  irq_events;

    // ==========================================================
    // Submodules
    mcal_edge_sync u_sin_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_in  (sync_in),
        .level   (sin_level),
        .rise    (sin_rise)
    );

    mcal_edge_sync u_cmt_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .pin_in  (commit_in),
        .level   (cmt_level),
        .rise    ()
    );

    mcal_clkgen u_clkgen (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .stall     (stall_reg),
        .phase     (phase),
        .rise_tick (rise_tick)
    );

    // ==========================================================
    // APB decode, one wait state per access
    assign access = psel && penable && pready_reg;
    assign wr_en  = access && pwrite;
    assign rd_en  = access && !pwrite;
    assign mapped = (paddr == OFF_FUNC_ONE) || (paddr == OFF_FUNC_TWO) ||
                    (paddr == OFF_IRQ_STAT) || (paddr == OFF_IRQ_MASK) ||
                    (paddr == OFF_STATE);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !mapped;
            prdata_reg  <= '0;
            if (psel && penable && !pready_reg && !pwrite) begin
                unique case (paddr)
                    OFF_FUNC_ONE: prdata_reg[1:0] <= fc1_buf_reg;
                    OFF_FUNC_TWO: begin
                        prdata_reg[7:0]     <= fc2_buf_reg;
                        prdata_reg[F2_LOST] <= sync_lost_reg;
                    end
                    OFF_IRQ_STAT: prdata_reg[IRQ_W-1:0] <= irq_stat_reg;
                    OFF_IRQ_MASK: prdata_reg[IRQ_W-1:0] <= irq_mask_reg;
                    OFF_STATE:    prdata_reg[1:0] <= phase;
                    default:      prdata_reg <= '0;
                endcase
            end
        end
    end

    // ==========================================================
    // Buffered control registers and directly written interrupt mask
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fc1_buf_reg <= F1_RESET;
            fc2_buf_reg <= F2_RESET;
            irq_mask_reg <= '0;
        end else if (wr_en) begin
            if (paddr == OFF_FUNC_ONE) begin
                fc1_buf_reg <= pwdata[1:0];
            end
            if (paddr == OFF_FUNC_TWO) begin
                fc2_buf_reg <= pwdata[7:0] & F2_WMASK;
            end
            if (paddr == OFF_IRQ_MASK) begin
                irq_mask_reg <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Commit strobe oversampled on each quarter-rate rising edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            commit_samp_reg <= 1'b0;
        end else if (rise_tick) begin
            commit_samp_reg <= cmt_level;
        end
    end

    assign commit_go = rise_tick && cmt_level && !commit_samp_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fc1_act_reg <= F1_RESET;
            fc2_act_reg <= F2_RESET;
        end else if (commit_go) begin
            fc1_act_reg <= fc1_buf_reg;
            fc2_act_reg <= fc2_buf_reg;
        end
    end

    assign act_sw     = fc1_act_reg[F1_MAN_SW];
    assign act_hw     = fc1_act_reg[F1_MAN_HW];
    assign act_master = fc2_act_reg[F2_MASTER];
    assign act_slave  = fc2_act_reg[F2_SLAVE] && !act_sw && !act_hw;
    assign act_mask   = fc2_act_reg[F2_MASK];
    assign act_ofs    = fc2_act_reg[F2_OFS_HI:F2_OFS_LO];

    // ==========================================================
    // Stall sources
    assign expect_phase = PULSE_PHASE + ALIGN_LAT + act_ofs;
    assign align_hit    = act_slave && sin_rise;
    assign mismatch     = align_hit && (phase != expect_phase);
    assign align_stall  = mismatch;
    assign sw_stall     = commit_go && act_sw && !fc1_buf_reg[F1_MAN_SW];
    assign hw_stall     = act_hw && sin_rise;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            stall_reg <= 1'b0;
        end else begin
            stall_reg <= align_stall || sw_stall || hw_stall;
        end
    end

    // ==========================================================
    // Sync-lost status, set wins over read clear
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_lost_reg <= 1'b0;
        end else if (act_mask) begin
            sync_lost_reg <= 1'b0;
        end else if (mismatch) begin
            sync_lost_reg <= 1'b1;
        end else if (rd_en && paddr == OFF_FUNC_TWO && prdata_reg[F2_LOST]) begin
            // Clear only a set that the read reported
            sync_lost_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Interrupt status, mask and output
    assign irq_events[IRQ_LOST]   = mismatch;
    assign irq_events[IRQ_COMMIT] = commit_go;
    assign irq_events[IRQ_STALL]  = stall_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_stat_reg <= '0;
        end else if (rd_en && paddr == OFF_IRQ_STAT) begin
            // Bits set after the read data was taken survive the clear
            irq_stat_reg <= (irq_stat_reg & ~prdata_reg[IRQ_W-1:0]) | irq_events;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_events;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ==========================================================
    // Pin outputs
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sync_out_reg <= 1'b0;
            sync_clk_reg <= 1'b0;
        end else begin
            sync_out_reg <= act_master && (phase == PULSE_PHASE) && !stall_reg;
            sync_clk_reg <= phase[1];
        end
    end

    assign sync_out     = sync_out_reg;
    assign sync_clk_out = sync_clk_reg;
    assign irq          = irq_reg;
    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = pslverr_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_master_pulse_width: assert property (sync_out_reg |=> !sync_out_reg)
        else $error("alignment pulse wider than one cycle");

    a_master_pulse_period: assert property (
        (sync_out_reg && act_master && !stall_reg) ##1 (!stall_reg && act_master)[*3]
        |=> sync_out_reg)
        else $error("alignment pulse period not four cycles");

    a_slave_mismatch_stall: assert property (mismatch |=> stall_reg ##1 !stall_reg)
        else $error("mismatch did not stall divider");

    a_stall_holds_phase: assert property (stall_reg |=> phase == $past(phase))
        else $error("stall did not hold divider phase");

    a_divider_advances: assert property (!stall_reg |=> phase == $past(phase) + 2'h1)
        else $error("divider did not advance");

    a_clk_follows_phase: assert property (##1 sync_clk_reg == $past(phase[1]))
        else $error("quarter-rate clock not phase msb");

    a_lost_sets: assert property (mismatch && !act_mask |=> sync_lost_reg)
        else $error("sync lost not set on mismatch");

    a_mask_holds_low: assert property (act_mask |=> !sync_lost_reg)
        else $error("masked sync lost went high");

    a_sw_commit_stall: assert property (
        $fell(act_sw) |-> stall_reg)
        else $error("software commit did not stall");

    a_hw_edge_stall: assert property (act_hw && sin_rise |=> stall_reg)
        else $error("hardware edge did not stall");

    a_commit_only_move: assert property (
        (fc2_act_reg != $past(fc2_act_reg)) |-> $past(commit_go))
        else $error("active register changed without commit");

    c_master_pulse: cover property (act_master && sync_out_reg);
    c_slave_stall:  cover property (mismatch ##1 stall_reg);
    c_commit:       cover property (commit_go);
    c_irq:          cover property ($rose(irq_reg));
endmodule
`default_nettype wire

// file: mcal_pkg.sv
// Constants shared by the multi-device clock alignment block
// Function
// - Master enable drives a one-cycle alignment pulse every four system clocks.
// - Slave enable makes the device sample pulses arriving on its alignment input.
// - Slave compares its divider phase with the pulse; mismatch stalls one cycle.
// - Automatic alignment brings a slave into step within three quarter-rate periods.
// - Two-bit offset, default 00, adds zero to three cycles of pulse travel delay.
// - Slave out of step sets sync-lost status; reading it clears it.
// - Alignment runs regardless of status; mask bit holds sync-lost status low.
// - Manual software mode: commit clearing its bit stalls the divider one cycle.
// - Each single stall shifts the quarter-rate clock by one system clock.
// - Manual hardware mode stalls the divider once per alignment input rising edge.
// - Quarter-rate output clock is the system clock divided by four, driven out.
// - Function control register writes stay buffered until a commit strobe sampled on quarter-rate clock.
// - Strobe meeting set-up to quarter-rate clock gives constant latency.
package mcal_pkg;
    // ==========================================================
    // Bus layout
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  OFF_FUNC_ONE  = 8'h00;
    localparam logic [7:0]  OFF_FUNC_TWO  = 8'h04;
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h08;
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h0c;
    localparam logic [7:0]  OFF_STATE     = 8'h10;
    // ==========================================================
    // function_control_one fields
    localparam int          F1_MAN_SW     = 0;
    localparam int          F1_MAN_HW     = 1;
    localparam logic [1:0]  F1_RESET      = 2'h0;
    // ==========================================================
    // function_control_two fields
    localparam int          F2_OFS_LO     = 0;
    localparam int          F2_OFS_HI     = 1;
    localparam int          F2_MASK       = 4;
    localparam int          F2_LOST       = 5;
    localparam int          F2_MASTER     = 6;
    localparam int          F2_SLAVE      = 7;
    localparam logic [7:0]  F2_RESET      = 8'h00;
    localparam logic [7:0]  F2_WMASK      = 8'hd3;
    // ==========================================================
    // Interrupt status bits
    localparam int          IRQ_W         = 3;
    localparam int          IRQ_LOST      = 0;
    localparam int          IRQ_COMMIT    = 1;
    localparam int          IRQ_STALL     = 2;
    // ==========================================================
    // Divider and alignment timing
    localparam logic [1:0]  PHASE_RESET   = 2'h0;
    localparam logic [1:0]  PHASE_RISE    = 2'h1;
    localparam logic [1:0]  PULSE_PHASE   = 2'h3;
    localparam logic [1:0]  ALIGN_LAT     = 2'h3;
endpackage

// file: mcal_edge_sync.sv
// Two-stage synchroniser with rising edge detector for a pin input
`timescale 1ns/1ps
`default_nettype none
module mcal_edge_sync (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Pin side
    input  wire logic pin_in,
    // Synchronised side
    output logic      level,
    output logic      rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;
endmodule
`default_nettype wire

// file: mcal_clkgen.sv
// Divide-by-four clock generator state machine with single-cycle stall
`timescale 1ns/1ps
`default_nettype none
module mcal_clkgen
    import mcal_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Control
    input  wire logic       stall,
    // State
    output logic [1:0]      phase,
    output logic            rise_tick
);
    logic [1:0] phase_reg;

    // Stall holds the phase, shifting the output by one system clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            phase_reg <= PHASE_RESET;
        end else if (!stall) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    assign phase     = phase_reg;
    assign rise_tick = (phase_reg == PHASE_RISE) && !stall;
endmodule
`default_nettype wire

// file: mcal_partner.sv
// Far-side model: commit strobe driver and alignment pulse travel path
`timescale 1ns/1ps
`default_nettype none
module mcal_partner (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       sys_rst,
    // Bench control
    input  wire logic       commit_req,
    input  wire logic [1:0] dly,
    input  wire logic       man_sel,
    input  wire logic       man_lvl,
    // Pin side
    input  wire logic       pulse_in,
    output logic            commit_out,
    output logic            busy,
    output logic            sync_pin
);
    logic [2:0] pipe_reg;
    logic [4:0] cnt_reg;
    wire  [3:0] taps = {pipe_reg, pulse_in};
    // ==========================================
    // Pulse travel delay of 0 to 3 cycles
    always_ff @(posedge ref_clk) begin
        pipe_reg <= sys_rst ? 3'h0 : {pipe_reg[1:0], pulse_in};
    end
    assign sync_pin = man_sel ? man_lvl : taps[dly];
    // ==========================================
    // Strobe high 8 cycles, then low 8 cycles
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            cnt_reg <= 5'h0;
        else if (commit_req && cnt_reg == 5'h0)
            cnt_reg <= 5'h10;
        else if (cnt_reg != 5'h0)
            cnt_reg <= cnt_reg - 5'h1;
    end
    assign commit_out = cnt_reg > 5'h8;
    assign busy       = cnt_reg != 5'h0;
endmodule
`default_nettype wire

// file: multi_device_clock_alignment_tb.sv
// Self-checking bench: master and slave devices with a far-side model
`timescale 1ns/1ps
`default_nettype none
module multi_device_clock_alignment_tb;
    import mcal_pkg::*;
    logic              ref_clk = 0, sys_rst = 1, psel_m = 0, psel_s = 0, penable = 0, pwrite = 0;
    logic [7:0]        paddr = 8'h0;
    logic [31:0]       pwdata = 32'h0, prd_m, prd_s, rd;
    logic              rdy_m, rdy_s, err_m, err_s, er, so_m, so_s, clk_m, clk_s, irq_m, irq_s;
    logic              commit_req = 0, man_sel = 1, man_lvl = 0, commit_pin, busy, sync_pin;
    logic [1:0]        dly = 2'h0;
    logic [31:0]       mdl [2][4] = '{default: '0};
    logic [7:0]        b;
    logic [7:0]        offs [4] = '{OFF_FUNC_ONE, OFF_FUNC_TWO, OFF_IRQ_STAT, OFF_IRQ_MASK};
    int                fail_count = 0, total_checks = 0, cyc = 0, k, n;

    always #2.5 ref_clk = ~ref_clk;

    mcal_top mcal_top_mst_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel_m), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd_m), .pready(rdy_m), .pslverr(err_m),
        .sync_in(1'b0), .commit_in(commit_pin), .sync_out(so_m), .sync_clk_out(clk_m), .irq(irq_m));
    mcal_top mcal_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel_s), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prd_s), .pready(rdy_s), .pslverr(err_s),
        .sync_in(sync_pin), .commit_in(commit_pin), .sync_out(so_s), .sync_clk_out(clk_s), .irq(irq_s));
    mcal_partner mcal_partner_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .commit_req(commit_req), .dly(dly),
        .man_sel(man_sel), .man_lvl(man_lvl), .pulse_in(so_m), .commit_out(commit_pin), .busy(busy),
        .sync_pin(sync_pin));

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] wmask(input logic [7:0] a);
        case (a)
            OFF_FUNC_ONE: return 32'h3;
            OFF_FUNC_TWO: return {24'h0, F2_WMASK};
            OFF_IRQ_MASK: return 32'h7;
            default:      return 32'h0;
        endcase
    endfunction

    task automatic apb(input bit s, input bit w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel_m <= !s;
        psel_s <= s;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while ((s ? rdy_s : rdy_m) !== 1'b1);
        rd = s ? prd_s : prd_m;
        er = s ? err_s : err_m;
        psel_m  <= 1'b0;
        psel_s  <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input bit s, input logic [7:0] a, input logic [31:0] d);
        apb(s, 1'b1, a, d);
        mdl[s][a[3:2]] = d & wmask(a);
    endtask

    task automatic rdchk(input bit s, input logic [7:0] a, input logic [31:0] extra);
        apb(s, 1'b0, a, 32'h0);
        chk(rd, mdl[s][a[3:2]] | extra);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic commit();
        commit_req <= 1'b1;
        @(posedge ref_clk);
        commit_req <= 1'b0;
        do @(posedge ref_clk); while (busy);
        repeat (8) @(posedge ref_clk);
    endtask

    // Slave lag behind master in system clocks, -1 if no match
    task automatic lag(output int r);
        logic [7:0] m, s;
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            m[i] = clk_m;
            s[i] = clk_s;
        end
        chk({28'h0, m[3:0]}, {28'h0, m[7:4]});
        chk(32'($countones(m)), 32'd4);
        r = -1;
        for (int j = 3; j >= 0; j--)
            if (s[7:4] === m[7-j -: 4])
                r = j;
    endtask

    task automatic grab();
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            b[i] = so_m;
        end
    endtask

    initial begin
        void'($urandom(63));
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (offs[i])
            rdchk(1'b1, offs[i], 32'h0);
        apb(1'b1, 1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        wr(1'b1, OFF_IRQ_MASK, $urandom);
        rdchk(1'b1, OFF_IRQ_MASK, 32'h0);
        chk({31'h0, irq_s}, 32'h0);
        apb(1'b1, 1'b0, OFF_STATE, 32'h0);
        chk(rd & 32'hffff_fffc, 32'h0);
        chk({31'h0, er}, 32'h0);
        $display("done: registers");
        wr(1'b0, OFF_FUNC_TWO, 32'h40);
        grab();
        chk({24'h0, b}, 32'h0);
        commit();
        grab();
        chk({28'h0, b[3:0]}, {28'h0, b[7:4]});
        chk(32'($countones(b)), 32'd2);
        $display("done: master pulse");
        for (int i = 1; i <= 4; i++) begin
            wr(1'b1, OFF_FUNC_ONE, 32'h1);
            commit();
            wr(1'b1, OFF_FUNC_ONE, 32'h0);
            commit();
            lag(k);
            chk(32'(k), 32'(i % 4));
        end
        $display("done: manual software");
        n = $urandom_range(3, 1);
        wr(1'b1, OFF_FUNC_ONE, 32'h2);
        commit();
        repeat (n) begin
            man_lvl <= 1'b1;
            repeat (4) @(posedge ref_clk);
            man_lvl <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        lag(k);
        chk(32'(k), 32'(n));
        wr(1'b1, OFF_FUNC_ONE, 32'h0);
        commit();
        $display("done: manual hardware");
        wr(1'b1, OFF_IRQ_MASK, 32'h1);
        man_sel <= 1'b0;
        wr(1'b1, OFF_FUNC_TWO, 32'h80);
        commit();
        lag(k);
        chk(32'(k), 32'h0);
        chk({31'h0, irq_s}, 32'h1);
        rdchk(1'b1, OFF_FUNC_TWO, 32'h20);
        rdchk(1'b1, OFF_FUNC_TWO, 32'h0);
        apb(1'b1, 1'b0, OFF_IRQ_STAT, 32'h0);
        chk(rd & 32'h1, 32'h1);
        repeat (3) @(posedge ref_clk);
        chk({31'h0, irq_s}, 32'h0);
        $display("done: automatic alignment");
        for (int o = 0; o < 4; o++) begin
            dly <= 2'(o);
            wr(1'b1, OFF_FUNC_TWO, 32'h90 | 32'(o));
            commit();
            lag(k);
            chk(32'(k), 32'h0);
            rdchk(1'b1, OFF_FUNC_TWO, 32'h0);
        end
        $display("done: offsets and mask");
        finish_test();
    end
endmodule
`default_nettype wire
